// File: rtl/rcr_pkg.sv
// rcr_pkg: constants for the repeater configuration register block.
// assumes nothing beyond a SystemVerilog compiler.
package rcr_pkg;
   localparam int DATA_W = 16;
   localparam int ADDR_W = 5;
   localparam logic [ADDR_W-1:0] REPEATER_CONFIGURATION_OFS = 5'h00;

   // field positions
   localparam int BIT_FSM_HOLD = 0;
   localparam int BIT_PASSTHROUGH = 1;
   localparam int BIT_PART_DIS = 2;
   localparam int BIT_SHORT_LIMIT = 3;
   localparam int BIT_MGMT_EN = 4;
   localparam int BIT_REGEN = 5;
   localparam int IMPL_W = 6;

   localparam logic [DATA_W-1:0] WRITABLE_MASK = 16'h003f;
   localparam logic [DATA_W-1:0] CONFIG_RESET = 16'h0000;

   // both mode pins high selects preamble regeneration
   localparam logic [1:0] MODE_REGEN = 2'h3;

   // preamble regeneration latency in clocks
   localparam logic [3:0] REGEN_DELAY_TX = 4'h4;
   localparam logic [3:0] REGEN_DELAY_T4 = 4'hc;

   // consecutive collision limits and partition thresholds
   localparam logic [6:0] COL_LIMIT_LONG = 7'h40;
   localparam logic [6:0] COL_LIMIT_SHORT = 7'h20;
   localparam logic [6:0] PART_AT_LONG = 7'h41;
   localparam logic [6:0] PART_AT_SHORT = 7'h21;

   // cycles after reset release at which the mode pins are sampled
   localparam logic [1:0] STRAP_CYCLE = 2'h3;
endpackage

// File: rtl/rcr_sync.sv
// rcr_sync: two-flop synchroniser for a vector of asynchronous levels.
// assumes inputs are quasi-static relative to sys_clk.
`timescale 1ns/1ps
module rcr_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic sys_clk, // clock
   input wire logic sys_rst, // synchronous reset, high
   input wire logic [W-1:0] async_in, // level from a pin
   output logic [W-1:0] sync_out // synchronised level
);
   logic [W-1:0] meta_q;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         meta_q <= INIT;
         sync_out <= INIT;
      end else begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule

// File: rtl/rcr_top.sv
// rcr_top: repeater configuration register with its control outputs.
// assumes reg_* and serial phase inputs come from the serial framing logic on sys_clk;
// mode pins and inter_repeater_busy_n are asynchronous pins.
`timescale 1ns/1ps
module rcr_top (
   input wire logic sys_clk, // 40 MHz clock
   input wire logic sys_rst, // synchronous reset, high
   input wire logic reg_wr, // register write strobe
   input wire logic reg_rd, // register read strobe
   input wire logic [rcr_pkg::ADDR_W-1:0] reg_addr, // register address
   input wire logic [rcr_pkg::DATA_W-1:0] reg_wdata, // write data
   output logic [rcr_pkg::DATA_W-1:0] reg_rdata, // read data, one cycle after reg_rd
   output logic reg_hit, // last access hit this register
   input wire logic [1:0] mode_pins, // repeater mode pins
   input wire logic inter_repeater_busy_n, // inter-repeater active, low
   output logic preamble_start, // one-cycle pulse: begin preamble regeneration
   output logic preamble_regen_mode, // regen bit
   output logic mgmt_counter_enable, // counters may count
   output logic short_collision_limit, // limit bit
   output logic [6:0] collision_limit, // consecutive collision limit
   output logic [6:0] partition_at, // collision count that partitions
   output logic autopartition_disable, // auto-partition off
   output logic phy_passthrough_enable, // PHY register pass-through
   output logic repeater_fsm_hold, // repeater state machines held in reset
   input wire logic read_phase, // serial engine is in a read data phase
   input wire logic phy_data_in, // data returned by local PHYs
   output logic register_serial_io_o, // serial data line output
   output logic register_serial_io_oe_n // serial data line drive, low drives
);
   logic [rcr_pkg::IMPL_W-1:0] cfg_q;
   logic [1:0] mode_s;
   logic busy_n_s;
   logic busy_n_prev_q;
   logic [1:0] strap_cnt_q;
   logic [3:0] regen_cnt_q;
   logic sel;
   logic busy_fall;

   rcr_sync #(.W(2), .INIT(2'h0)) u_mode_sync (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .async_in(mode_pins),
      .sync_out(mode_s)
   );

   rcr_sync #(.W(1), .INIT(1'h1)) u_busy_sync (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .async_in(inter_repeater_busy_n),
      .sync_out(busy_n_s)
   );

   assign sel = (reg_addr == rcr_pkg::REPEATER_CONFIGURATION_OFS);
   assign busy_fall = busy_n_prev_q & ~busy_n_s;

   // counts cycles after reset release until the mode pins are settled
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         strap_cnt_q <= 2'h0;
      end else if (strap_cnt_q != rcr_pkg::STRAP_CYCLE) begin
         strap_cnt_q <= strap_cnt_q + 2'h1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         cfg_q <= rcr_pkg::CONFIG_RESET[rcr_pkg::IMPL_W-1:0];
      end else begin
         // software write of all implemented bits
         if (reg_wr && sel) begin
            cfg_q <= reg_wdata[rcr_pkg::IMPL_W-1:0];
         end
         if (strap_cnt_q == rcr_pkg::STRAP_CYCLE - 2'h1) begin
            cfg_q[rcr_pkg::BIT_REGEN] <= (mode_s == rcr_pkg::MODE_REGEN);
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         reg_rdata <= '0;
         reg_hit <= 1'b0;
      end else if (reg_rd || reg_wr) begin
         reg_hit <= sel;
         if (reg_rd) begin
            reg_rdata <= sel ? {{(rcr_pkg::DATA_W-rcr_pkg::IMPL_W){1'b0}}, cfg_q} : '0;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         preamble_regen_mode <= 1'b0;
         mgmt_counter_enable <= 1'b0;
         short_collision_limit <= 1'b0;
         autopartition_disable <= 1'b0;
         phy_passthrough_enable <= 1'b0;
         repeater_fsm_hold <= 1'b0;
         collision_limit <= rcr_pkg::COL_LIMIT_LONG;
         partition_at <= rcr_pkg::PART_AT_LONG;
      end else begin
         preamble_regen_mode <= cfg_q[rcr_pkg::BIT_REGEN];
         mgmt_counter_enable <= cfg_q[rcr_pkg::BIT_MGMT_EN];
         short_collision_limit <= cfg_q[rcr_pkg::BIT_SHORT_LIMIT];
         autopartition_disable <= cfg_q[rcr_pkg::BIT_PART_DIS];
         phy_passthrough_enable <= cfg_q[rcr_pkg::BIT_PASSTHROUGH];
         // the repeater machines and the preamble latency counter see the hold, not the management counters
         repeater_fsm_hold <= cfg_q[rcr_pkg::BIT_FSM_HOLD];
         if (cfg_q[rcr_pkg::BIT_SHORT_LIMIT]) begin
            collision_limit <= rcr_pkg::COL_LIMIT_SHORT;
            partition_at <= rcr_pkg::PART_AT_SHORT;
         end else begin
            collision_limit <= rcr_pkg::COL_LIMIT_LONG;
            partition_at <= rcr_pkg::PART_AT_LONG;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         busy_n_prev_q <= 1'b1;
      end else begin
         busy_n_prev_q <= busy_n_s;
      end
   end

   // preamble latency: TX when regen bit set, T4 otherwise, cleared while held
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         regen_cnt_q <= 4'h0;
         preamble_start <= 1'b0;
      end else begin
         preamble_start <= 1'b0;
         if (cfg_q[rcr_pkg::BIT_FSM_HOLD]) begin
            regen_cnt_q <= 4'h0;
         end else if (busy_fall) begin
            regen_cnt_q <= cfg_q[rcr_pkg::BIT_REGEN] ? rcr_pkg::REGEN_DELAY_TX
                                                      : rcr_pkg::REGEN_DELAY_T4;
         end else if (regen_cnt_q != 4'h0) begin
            regen_cnt_q <= regen_cnt_q - 4'h1;
            if (regen_cnt_q == 4'h1) begin
               preamble_start <= 1'b1;
            end
         end
      end
   end

   // drive the serial line in read phases while passthrough is on
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         register_serial_io_o <= 1'b0;
         register_serial_io_oe_n <= 1'b1;
      end else begin
         register_serial_io_o <= phy_data_in;
         register_serial_io_oe_n <= ~(cfg_q[rcr_pkg::BIT_PASSTHROUGH] & read_phase);
      end
   end

   chk_reserved_zero: assert property (@(posedge sys_clk) disable iff (sys_rst)
      reg_rdata[rcr_pkg::DATA_W-1:rcr_pkg::IMPL_W] == '0)
      else $error("reserved config bits read nonzero");
   chk_write_readback: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (reg_wr && sel && !reg_rd && strap_cnt_q == rcr_pkg::STRAP_CYCLE)
      ##1 (reg_rd && sel && !reg_wr)
      |=> reg_rdata == {10'h000, $past(reg_wdata[rcr_pkg::IMPL_W-1:0], 2)})
      else $error("config readback differs from written value");
   chk_strap_regen: assert property (@(posedge sys_clk)
      (strap_cnt_q == rcr_pkg::STRAP_CYCLE - 2'h1 && !sys_rst)
      |=> cfg_q[rcr_pkg::BIT_REGEN] == ($past(mode_s) == rcr_pkg::MODE_REGEN))
      else $error("regen bit not strapped from mode pins");
   chk_tx_latency: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (busy_fall && cfg_q[rcr_pkg::BIT_REGEN] && !cfg_q[rcr_pkg::BIT_FSM_HOLD])
      ##1 (!busy_fall && !cfg_q[rcr_pkg::BIT_FSM_HOLD]) [*4]
      |=> preamble_start)
      else $error("tx preamble start not four clocks after busy");
   chk_t4_latency: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (busy_fall && !cfg_q[rcr_pkg::BIT_REGEN] && !cfg_q[rcr_pkg::BIT_FSM_HOLD])
      |=> !preamble_start [*8])
      else $error("t4 preamble start too early");
   chk_counter_gate: assert property (@(posedge sys_clk) disable iff (sys_rst)
      mgmt_counter_enable == $past(cfg_q[rcr_pkg::BIT_MGMT_EN]))
      else $error("counter enable does not follow config");
   chk_limit_pair: assert property (@(posedge sys_clk) disable iff (sys_rst)
      partition_at == collision_limit + 7'h01 &&
      (short_collision_limit ? collision_limit == rcr_pkg::COL_LIMIT_SHORT
                             : collision_limit == rcr_pkg::COL_LIMIT_LONG))
      else $error("collision limit mismatched with limit bit");
   chk_short_limit: assert property (@(posedge sys_clk) disable iff (sys_rst)
      $rose(short_collision_limit) |-> partition_at == rcr_pkg::PART_AT_SHORT)
      else $error("short limit not applied");
   chk_part_dis: assert property (@(posedge sys_clk) disable iff (sys_rst)
      $past(cfg_q[rcr_pkg::BIT_PART_DIS]) |-> autopartition_disable)
      else $error("partition disable not passed out");
   chk_serial_drive: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !register_serial_io_oe_n |-> $past(phy_passthrough_enable | cfg_q[rcr_pkg::BIT_PASSTHROUGH])
      && $past(read_phase))
      else $error("serial line driven outside passthrough read phase");
   chk_hold_quiet: assert property (@(posedge sys_clk) disable iff (sys_rst)
      $past(cfg_q[rcr_pkg::BIT_FSM_HOLD]) |-> !preamble_start)
      else $error("preamble start while held");
   cov_tx_start: cover property (@(posedge sys_clk) disable iff (sys_rst)
      preamble_start && preamble_regen_mode);
   cov_t4_start: cover property (@(posedge sys_clk) disable iff (sys_rst)
      preamble_start && !preamble_regen_mode);
   cov_passthrough_read: cover property (@(posedge sys_clk) disable iff (sys_rst)
      !register_serial_io_oe_n);
endmodule

// File: tb/rcr_agent.sv
// rcr_agent: management agent model that drives the register strobes.
// assumes command inputs change just after a rising edge of sys_clk.
`timescale 1ns/1ps
module rcr_agent (
   input wire logic cmd_wr, // write request
   input wire logic cmd_rd, // read request
   input wire logic cmd_raw, // send reserved bits unmasked, on purpose
   input wire logic [rcr_pkg::ADDR_W-1:0] cmd_addr, // target address
   input wire logic [rcr_pkg::DATA_W-1:0] cmd_data, // value to write
   output logic reg_wr, // write strobe
   output logic reg_rd, // read strobe
   output logic [rcr_pkg::ADDR_W-1:0] reg_addr, // address
   output logic [rcr_pkg::DATA_W-1:0] reg_wdata // write data
);
   assign reg_wr = cmd_wr;
   assign reg_rd = cmd_rd;
   assign reg_addr = cmd_addr;
   // reserved bits written zero unless cmd_raw is set; idle data is scrambled
   assign reg_wdata = !cmd_wr ? ~cmd_data : cmd_raw ? cmd_data
                                                    : (cmd_data & rcr_pkg::WRITABLE_MASK);
endmodule

// File: tb/test_repeater_config_register.sv
// test_repeater_config_register: self-checking bench for rcr_top.
// assumes rcr_pkg is compiled first and the agent model sits beside the design.
`timescale 1ns/1ps
module test_repeater_config_register;
   logic sys_clk = 1'b0, sys_rst = 1'b1, cmd_wr = 1'b0, cmd_rd = 1'b0, cmd_raw = 1'b0;
   logic [4:0] cmd_addr = 5'h00, reg_addr;
   logic [15:0] cmd_data = 16'h0000, reg_wdata, reg_rdata;
   logic [1:0] mode_pins = 2'h3;
   logic inter_repeater_busy_n = 1'b1, read_phase = 1'b0, phy_data_in = 1'b0;
   logic reg_wr, reg_rd, reg_hit, preamble_start, preamble_regen_mode, mgmt_counter_enable;
   logic short_collision_limit, autopartition_disable, phy_passthrough_enable;
   logic repeater_fsm_hold, register_serial_io_o, register_serial_io_oe_n;
   logic [6:0] collision_limit, partition_at;
   logic [5:0] cfg;
   logic [15:0] d, q;
   logic [4:0] a;
   int err_total = 0, n_checks = 0, seed = 32'he123;

   always #12.5 sys_clk = ~sys_clk;

   rcr_agent i_agent (.cmd_wr, .cmd_rd, .cmd_raw, .cmd_addr, .cmd_data, .reg_wr, .reg_rd,
      .reg_addr, .reg_wdata);
   rcr_top i_dut (.sys_clk, .sys_rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
      .reg_hit, .mode_pins, .inter_repeater_busy_n, .preamble_start, .preamble_regen_mode,
      .mgmt_counter_enable, .short_collision_limit, .collision_limit, .partition_at,
      .autopartition_disable, .phy_passthrough_enable, .repeater_fsm_hold, .read_phase,
      .phy_data_in, .register_serial_io_o, .register_serial_io_oe_n);

   task automatic conclude();
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   function automatic logic [15:0] exp_limit(input logic short_lim, input logic part);
      return short_lim ? (part ? 16'h0021 : 16'h0020) : (part ? 16'h0041 : 16'h0040);
   endfunction

   task automatic wr(input logic [4:0] addr, input logic [15:0] data, input logic raw);
      @(posedge sys_clk);
      cmd_wr <= 1'b1;
      cmd_addr <= addr;
      cmd_data <= data;
      cmd_raw <= raw;
      @(posedge sys_clk);
      cmd_wr <= 1'b0;
      repeat (2) @(posedge sys_clk);
      #1;
   endtask

   task automatic rd(input logic [4:0] addr, output logic [15:0] val);
      @(posedge sys_clk);
      cmd_rd <= 1'b1;
      cmd_addr <= addr;
      @(posedge sys_clk);
      cmd_rd <= 1'b0;
      @(posedge sys_clk);
      #1;
      val = reg_rdata;
   endtask

   // write then read on the very next cycle, so the read sees the fresh value
   task automatic wr_rd(input logic [15:0] data, output logic [15:0] val);
      @(posedge sys_clk);
      cmd_wr <= 1'b1;
      cmd_addr <= 5'h00;
      cmd_data <= data;
      cmd_raw <= 1'b0;
      @(posedge sys_clk);
      cmd_wr <= 1'b0;
      cmd_rd <= 1'b1;
      @(posedge sys_clk);
      cmd_rd <= 1'b0;
      @(posedge sys_clk);
      #1;
      val = reg_rdata;
   endtask

   task automatic chk_cfg(input logic [5:0] c);
      logic [15:0] v;
      check({10'h0, preamble_regen_mode, mgmt_counter_enable, short_collision_limit,
         autopartition_disable, phy_passthrough_enable, repeater_fsm_hold}, {10'h0, c},
         "levels");
      check({9'h0, collision_limit}, exp_limit(c[3], 1'b0), "limit");
      check({9'h0, partition_at}, exp_limit(c[3], 1'b1), "partition");
      rd(5'h00, v);
      check(v, {10'h0, c}, "readback");
   endtask

   task automatic do_reset(input logic [1:0] pins);
      @(posedge sys_clk);
      mode_pins <= pins;
      sys_rst <= 1'b1;
      repeat (12) @(posedge sys_clk);
      sys_rst <= 1'b0;
      repeat (6) @(posedge sys_clk);
      #1;
   endtask

   task automatic relay(input logic pass);
      logic rp, pd;
      repeat (4) begin
         @(posedge sys_clk);
         rp = 1'($random(seed));
         pd = 1'($random(seed));
         read_phase <= rp;
         phy_data_in <= pd;
         @(posedge sys_clk);
         #1;
         check({15'h0, register_serial_io_oe_n}, {15'h0, ~(rp & pass)}, "drive");
         if (rp & pass) check({15'h0, register_serial_io_o}, {15'h0, pd}, "relay");
      end
   endtask

   // lo and hi bound the edges from pin fall to the pulse; 40 means none expected
   task automatic busy(input int lo, input int hi);
      int n;
      @(posedge sys_clk);
      inter_repeater_busy_n <= 1'b0;
      n = 0;
      do begin
         @(posedge sys_clk);
         #1;
         n++;
      end while (preamble_start !== 1'b1 && n < 40);
      check({15'h0, n >= lo && n <= hi}, 16'h0001, "preamble latency");
      if (n == 40 && lo < 40) conclude();
      @(posedge sys_clk);
      inter_repeater_busy_n <= 1'b1;
      repeat (6) @(posedge sys_clk);
   endtask

   initial begin
      repeat (20000) @(posedge sys_clk);
      err_total++;
      conclude();
   end

   initial begin
      do_reset(2'h3);
      chk_cfg(6'h20);
      do_reset(2'h1);
      chk_cfg(6'h00);
      cfg = 6'h00;
      for (int i = 0; i < 24; i++) begin
         d = 16'($random(seed));
         a = (i % 3 == 2) ? {1'b1, d[9:6]} : 5'h00;
         if (i == 0) d = 16'hffff;
         if (i == 1) d = 16'h0000;
         if (a != 5'h00 && cfg[4]) begin
            cfg[4] = 1'b0;
            wr(5'h00, {10'h000, cfg}, 1'b0);
         end
         wr(a, d, 1'b1);
         if (a == 5'h00) cfg = d[5:0];
         chk_cfg(cfg);
         rd(a, q);
         if (a != 5'h00) check(q, 16'h0000, "unmapped read");
         check({15'h0, reg_hit}, {15'h0, a == 5'h00}, "hit");
         relay(cfg[1]);
      end
      wr_rd(16'h0016, q);
      check(q, 16'h0016, "back to back readback");
      wr(5'h00, 16'h0020, 1'b0);
      busy(6, 9);
      wr(5'h00, 16'h0000, 1'b0);
      busy(14, 17);
      wr(5'h00, 16'h0021, 1'b0);
      busy(40, 40);
      conclude();
   end
endmodule
